// ===== src/mcs_pkg.sv
// constants, register table and types of the machine cycle sequencer
// assumes a single clock domain in which one clock period is one oscillator period
package mcs_pkg;

	// six states of a machine cycle
	typedef enum logic [2:0] {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6} mcs_state_t;

	// special function register table, one entry per implemented byte address
	localparam int SFR_COUNT = 24;
	localparam logic [7:0] SFR_ADDR [SFR_COUNT] = '{
		8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90,
		8'h91, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'ha0, 8'ha1};
	// port0_latch stack_pointer data_pointer_low data_pointer_high power_control timer_control
	// timer_mode timer0_low timer1_low timer0_high timer1_high port1_latch port1_function_select
	// port3_function_select port4_function_select adc_clock_prescaler adc_result adc_control
	// serial0_control serial0_buffer serial1_control serial1_buffer port2_latch pwm_control
	localparam logic [7:0] SFR_RESET [SFR_COUNT] = '{
		8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
	// adc_result is read only
	localparam logic [SFR_COUNT-1:0] SFR_READ_ONLY = 24'h01_0000;
	localparam int IDX_DATA_POINTER_LOW  = 2;
	localparam int IDX_DATA_POINTER_HIGH = 3;
	localparam int IDX_PORT2_LATCH       = 22;

	// apb word indexes, byte address is four times the index
	localparam logic [9:0] REG_CONTROL    = 10'h000;
	localparam logic [9:0] REG_STATUS     = 10'h001;
	localparam logic [9:0] REG_ACCUM      = 10'h002;
	localparam logic [9:0] REG_BIT_ACCESS = 10'h004;
	localparam logic [6:0] REG_WORK_BASE  = 7'h01;
	localparam logic [2:0] REG_SFR_BASE   = 3'h1;

	// control fields and reset values
	localparam int CTRL_RUN_BIT     = 0;
	localparam int CTRL_MEM_RST_BIT = 1;
	localparam int BIT_VALUE_BIT    = 8;
	localparam logic [1:0]  CONTROL_RESET = 2'h1;
	localparam logic [7:0]  ACCUM_RESET   = 8'h00;
	localparam logic [7:0]  WORK_RESET    = 8'h00;
	localparam logic [15:0] PC_RESET      = 16'h0000;
	localparam logic [7:0]  IR_RESET      = 8'h00;
	localparam logic [7:0]  BIT_ADDR_RESET = 8'h80;

	// opcodes the sequencer understands
	localparam logic [7:0] OP_DECREMENT_BRANCH_NONZERO_DIRECT   = 8'hd5;
	localparam logic [4:0] OP_DECREMENT_BRANCH_NONZERO_REG_TOP  = 5'h1b;
	localparam logic [7:0] OP_MOV_A_IMM     = 8'h74;
	localparam logic [2:0] OP_EXTERNAL_DATA_MOVE_TOP      = 3'h7;

endpackage

// ===== src/mcs_sequencer.sv
// machine cycle sequencer: state timing, program fetch, external data moves and the register space
// assumes an apb master on pclk and a memory module on the same clock answering within a state
//
// The APB register port was decided locally.
`timescale 1ns/1ps

module mcs_sequencer (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// memory module bus
	output logic      [15:0] mem_addr,
	input  wire logic [7:0]  mem_rdata,
	output logic      [7:0]  mem_wdata,
	output logic             mem_data_oe,
	output logic             mem_rd_n,
	output logic             mem_wr_n,
	output logic             program_fetch_strobe_n,
	output logic             mem_ale,
	output logic             mem_reset_n
);

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic [5:0] sfr_lookup(input logic [7:0] a);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < mcs_pkg::SFR_COUNT; i++) begin
			if (mcs_pkg::SFR_ADDR[i] == a) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic is_external_data_move(input logic [7:0] op);
		return op[7:5] == mcs_pkg::OP_EXTERNAL_DATA_MOVE_TOP && (op[3:0] == 4'h0 || op[3:1] == 3'h1);
	endfunction

	function automatic logic is_decrement_branch_nonzero(input logic [7:0] op);
		return op == mcs_pkg::OP_DECREMENT_BRANCH_NONZERO_DIRECT || op[7:3] == mcs_pkg::OP_DECREMENT_BRANCH_NONZERO_REG_TOP;
	endfunction

	function automatic logic [1:0] op_length(input logic [7:0] op);
		return op == mcs_pkg::OP_DECREMENT_BRANCH_NONZERO_DIRECT ? 2'h3
		     : (op[7:3] == mcs_pkg::OP_DECREMENT_BRANCH_NONZERO_REG_TOP || op == mcs_pkg::OP_MOV_A_IMM) ? 2'h2 : 2'h1;
	endfunction

	function automatic mcs_pkg::mcs_state_t state_after(input mcs_pkg::mcs_state_t s);
		mcs_pkg::mcs_state_t n;
		case (s)
			mcs_pkg::ST_S1: n = mcs_pkg::ST_S2;
			mcs_pkg::ST_S2: n = mcs_pkg::ST_S3;
			mcs_pkg::ST_S3: n = mcs_pkg::ST_S4;
			mcs_pkg::ST_S4: n = mcs_pkg::ST_S5;
			mcs_pkg::ST_S5: n = mcs_pkg::ST_S6;
			default:        n = mcs_pkg::ST_S1;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	mcs_pkg::mcs_state_t state;
	mcs_pkg::mcs_state_t next_state;
	logic                phase;
	logic                next_phase;
	logic                second_cycle;
	logic                next_second;
	logic [1:0]          ctrl;
	logic [15:0]         pc;
	logic [15:0]         next_pc;
	logic [7:0]          ir;
	logic [7:0]          op_b2;
	logic [7:0]          op_b3;
	logic [1:0]          got;
	logic [7:0]          acc;
	logic [7:0]          work [8];
	logic [7:0]          special_function_register [mcs_pkg::SFR_COUNT];
	logic [7:0]          bit_addr;

	logic                run;
	logic                fetch_now;
	logic                first_fetch;
	logic                need_byte;
	logic                exec_now;
	logic                external_data_move_data;
	logic                external_data_move_capture;
	logic                exec_decrement_branch_nonzero;
	logic [5:0]          decrement_branch_nonzero_lk;
	logic [7:0]          decrement_branch_nonzero_val;
	logic [7:0]          decrement_branch_nonzero_dec;
	logic [7:0]          decrement_branch_nonzero_rel;
	logic [15:0]         decrement_branch_nonzero_target;
	logic [15:0]         external_data_move_addr;

	assign run          = ctrl[mcs_pkg::CTRL_RUN_BIT];
	assign first_fetch  = state == mcs_pkg::ST_S1 && !second_cycle;
	assign external_data_move_data    = second_cycle && is_external_data_move(ir);
	assign need_byte    = got < op_length(ir);
	assign external_data_move_capture = run && phase && state == mcs_pkg::ST_S5 && external_data_move_data && !ir[4];
	assign exec_now     = run && phase && state == mcs_pkg::ST_S6 && !((is_external_data_move(ir) || is_decrement_branch_nonzero(ir)) && !second_cycle);
	assign exec_decrement_branch_nonzero    = exec_now && is_decrement_branch_nonzero(ir);
	assign decrement_branch_nonzero_lk      = sfr_lookup(op_b2);
	assign decrement_branch_nonzero_rel     = ir == mcs_pkg::OP_DECREMENT_BRANCH_NONZERO_DIRECT ? op_b3 : op_b2;
	assign decrement_branch_nonzero_dec     = 8'(decrement_branch_nonzero_val - 8'h01);
	assign decrement_branch_nonzero_target  = 16'(pc + {{8{decrement_branch_nonzero_rel[7]}}, decrement_branch_nonzero_rel});
	assign external_data_move_addr    = ir[1] ? {special_function_register[mcs_pkg::IDX_PORT2_LATCH], work[{2'h0, ir[0]}]}
	                            : {special_function_register[mcs_pkg::IDX_DATA_POINTER_HIGH], special_function_register[mcs_pkg::IDX_DATA_POINTER_LOW]};

	// fetch in first and fourth state
	// no fetch in second cycle of a data move
	assign fetch_now = run && phase && (state == mcs_pkg::ST_S1 || state == mcs_pkg::ST_S4) && !external_data_move_data;

	always_comb begin
		decrement_branch_nonzero_val = work[ir[2:0]];
		if (ir == mcs_pkg::OP_DECREMENT_BRANCH_NONZERO_DIRECT) begin
			if (op_b2[7]) begin
				decrement_branch_nonzero_val = decrement_branch_nonzero_lk[5] ? special_function_register[decrement_branch_nonzero_lk[4:0]] : 8'h00;
			end else begin
				decrement_branch_nonzero_val = op_b2[7:3] == 5'h00 ? work[op_b2[2:0]] : 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		next_phase  = run ? !phase : phase;
		next_state  = (run && phase) ? state_after(state) : state;
		next_second = second_cycle;
		if (run && phase && state == mcs_pkg::ST_S6) begin
			next_second = (is_external_data_move(ir) || is_decrement_branch_nonzero(ir)) && !second_cycle;
		end
	end

	// two periods per state, six states
	// start at state one, wrap after six
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state        <= mcs_pkg::ST_S1;
			phase        <= 1'b0;
			second_cycle <= 1'b0;
		end else begin
			state        <= next_state;
			phase        <= next_phase;
			second_cycle <= next_second;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fetch and program counter

	always_comb begin
		next_pc = pc;
		if (fetch_now && (first_fetch || need_byte)) begin
			next_pc = 16'(pc + 16'h0001);
		end
		if (exec_decrement_branch_nonzero && decrement_branch_nonzero_dec != 8'h00) begin
			next_pc = decrement_branch_nonzero_target;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc    <= mcs_pkg::PC_RESET;
			ir    <= mcs_pkg::IR_RESET;
			op_b2 <= 8'h00;
			op_b3 <= 8'h00;
			got   <= 2'h1;
		end else begin
			pc <= next_pc;
			if (fetch_now && first_fetch) begin
				ir  <= mem_rdata;
				got <= 2'h1;
			end else if (fetch_now && need_byte) begin
				if (got == 2'h1) begin
					op_b2 <= mem_rdata;
				end else begin
					op_b3 <= mem_rdata;
				end
				got <= 2'(got + 2'h1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb slave

	logic [9:0]  widx;
	logic        apb_wr;
	logic [5:0]  apb_lk;
	logic [5:0]  bit_lk;
	logic [31:0] read_value;
	logic        mapped;

	assign widx   = paddr[11:2];
	assign apb_wr = psel && penable && pready && pwrite;
	assign apb_lk = sfr_lookup(widx[7:0]);
	assign bit_lk = sfr_lookup({bit_addr[7:3], 3'h0});

	always_comb begin
		read_value = 32'h0000_0000;
		mapped     = 1'b1;
		if (widx[9:7] == mcs_pkg::REG_SFR_BASE) begin
			read_value = apb_lk[5] ? {24'h00_0000, special_function_register[apb_lk[4:0]]} : 32'h0000_0000;
		end else if (widx[9:3] == mcs_pkg::REG_WORK_BASE) begin
			read_value = {24'h00_0000, work[widx[2:0]]};
		end else begin
			case (widx)
				mcs_pkg::REG_CONTROL:    read_value = {30'h0000_0000, ctrl};
				mcs_pkg::REG_STATUS:     read_value = {pc, ir, 3'h0, second_cycle, phase, 3'(state)};
				mcs_pkg::REG_ACCUM:      read_value = {24'h00_0000, acc};
				mcs_pkg::REG_BIT_ACCESS: read_value = {23'h00_0000, bit_lk[5] && special_function_register[bit_lk[4:0]][bit_addr[2:0]],
				                                       bit_addr};
				default:                 mapped = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			prdata  <= read_value;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= mcs_pkg::CONTROL_RESET;
			bit_addr <= mcs_pkg::BIT_ADDR_RESET;
		end else if (apb_wr && widx == mcs_pkg::REG_CONTROL) begin
			ctrl <= pwdata[1:0];
		end else if (apb_wr && widx == mcs_pkg::REG_BIT_ACCESS) begin
			bit_addr <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// accumulator, working registers, special function registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= mcs_pkg::ACCUM_RESET;
		end else if (external_data_move_capture) begin
			acc <= mem_rdata;
		end else if (exec_now && ir == mcs_pkg::OP_MOV_A_IMM) begin
			acc <= op_b2;
		end else if (apb_wr && widx == mcs_pkg::REG_ACCUM) begin
			acc <= pwdata[7:0];
		end
	end

	// the core's own write wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				work[i] <= mcs_pkg::WORK_RESET;
			end
		end else begin
			if (apb_wr && widx[9:3] == mcs_pkg::REG_WORK_BASE) begin
				work[widx[2:0]] <= pwdata[7:0];
			end
			if (exec_decrement_branch_nonzero && ir != mcs_pkg::OP_DECREMENT_BRANCH_NONZERO_DIRECT) begin
				work[ir[2:0]] <= decrement_branch_nonzero_dec;
			end else if (exec_decrement_branch_nonzero && op_b2[7:3] == 5'h00) begin
				work[op_b2[2:0]] <= decrement_branch_nonzero_dec;
			end
		end
	end

	logic [5:0] bit_wr_lk;
	assign bit_wr_lk = sfr_lookup({pwdata[7:3], 3'h0});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < mcs_pkg::SFR_COUNT; i++) begin
				special_function_register[i] <= mcs_pkg::SFR_RESET[i];
			end
		end else begin
			if (apb_wr && widx[9:7] == mcs_pkg::REG_SFR_BASE && apb_lk[5] && !mcs_pkg::SFR_READ_ONLY[apb_lk[4:0]]) begin
				special_function_register[apb_lk[4:0]] <= pwdata[7:0];
			end
			// single bit write on aligned rows
			if (apb_wr && widx == mcs_pkg::REG_BIT_ACCESS && pwdata[7] && bit_wr_lk[5] &&
			    !mcs_pkg::SFR_READ_ONLY[bit_wr_lk[4:0]]) begin
				special_function_register[bit_wr_lk[4:0]][pwdata[2:0]] <= pwdata[mcs_pkg::BIT_VALUE_BIT];
			end
			if (exec_decrement_branch_nonzero && ir == mcs_pkg::OP_DECREMENT_BRANCH_NONZERO_DIRECT && op_b2[7] && decrement_branch_nonzero_lk[5] &&
			    !mcs_pkg::SFR_READ_ONLY[decrement_branch_nonzero_lk[4:0]]) begin
				special_function_register[decrement_branch_nonzero_lk[4:0]] <= decrement_branch_nonzero_dec;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// memory bus outputs

	logic nf;
	logic nd;
	assign nf = run && (next_state == mcs_pkg::ST_S1 || next_state == mcs_pkg::ST_S4) &&
	            !(next_second && is_external_data_move(ir));
	assign nd = run && next_second && is_external_data_move(ir);

	// address, data and strobes to memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_addr               <= 16'h0000;
			mem_wdata              <= 8'h00;
			mem_data_oe            <= 1'b0;
			mem_rd_n               <= 1'b1;
			mem_wr_n               <= 1'b1;
			program_fetch_strobe_n <= 1'b1;
			mem_ale                <= 1'b0;
			mem_reset_n            <= 1'b0;
		end else begin
			mem_addr               <= nd ? external_data_move_addr : next_pc;
			mem_wdata              <= acc;
			mem_data_oe            <= nd && ir[4] && next_state inside {mcs_pkg::ST_S2, mcs_pkg::ST_S3,
			                                                           mcs_pkg::ST_S4, mcs_pkg::ST_S5};
			mem_rd_n               <= !(nd && !ir[4] && next_state inside {mcs_pkg::ST_S2, mcs_pkg::ST_S3,
			                                                              mcs_pkg::ST_S4, mcs_pkg::ST_S5});
			mem_wr_n               <= !(nd && ir[4] && next_state inside {mcs_pkg::ST_S3, mcs_pkg::ST_S4,
			                                                             mcs_pkg::ST_S5});
			program_fetch_strobe_n <= !(nf && next_phase);
			mem_ale                <= (nf || (nd && next_state == mcs_pkg::ST_S1)) && !next_phase;
			mem_reset_n            <= !ctrl[mcs_pkg::CTRL_MEM_RST_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	state_hold_a: assert property (run && !phase |=> $stable(state))
		else $error("state changed in first phase");
	phase_step_a: assert property (run |=> phase != $past(phase))
		else $error("phase did not toggle");
	state_wrap_a: assert property (run && phase && state == mcs_pkg::ST_S6 |=> state == mcs_pkg::ST_S1 && !phase)
		else $error("sequencer did not wrap to state one");
	fetch_slot_a: assert property (!program_fetch_strobe_n |->
	                               (state == mcs_pkg::ST_S1 || state == mcs_pkg::ST_S4) && phase)
		else $error("fetch strobe outside a fetch slot");
	external_data_move_nofetch_a: assert property (external_data_move_data |-> program_fetch_strobe_n)
		else $error("fetch during second cycle of a data move");
	pc_discard_a: assert property (fetch_now && !first_fetch && !need_byte && !exec_decrement_branch_nonzero |=> pc == $past(pc))
		else $error("pc moved on a dropped fetch");
	opcode_latch_a: assert property (fetch_now && first_fetch |=> ir == $past(mem_rdata))
		else $error("opcode not latched in state one");
	decrement_branch_nonzero_branch_a: assert property (exec_decrement_branch_nonzero |=>
	                                pc == ($past(decrement_branch_nonzero_dec) != 8'h00 ? $past(decrement_branch_nonzero_target) : $past(pc)))
		else $error("decrement branch went the wrong way");
	strobe_excl_a: assert property (!(!mem_rd_n && !mem_wr_n) && !(!program_fetch_strobe_n && !mem_rd_n))
		else $error("memory strobes overlap");
	sfr_unmapped_a: assert property (apb_wr && widx[9:7] == mcs_pkg::REG_SFR_BASE && !apb_lk[5] && !exec_decrement_branch_nonzero |=>
	                                 special_function_register[0] == $past(special_function_register[0]) && special_function_register[23] == $past(special_function_register[23]))
		else $error("write to unoccupied address changed state");

	external_data_move_read_c: cover property (external_data_move_capture);
	decrement_branch_nonzero_taken_c: cover property (exec_decrement_branch_nonzero && decrement_branch_nonzero_dec != 8'h00);
	bit_write_c: cover property (apb_wr && widx == mcs_pkg::REG_BIT_ACCESS && bit_wr_lk[5]);

endmodule

// ===== sim/mcs_mem_model.sv
// behavioural program and data memory on the far side of the sequencer's memory bus
// assumes the sequencer's clock; the bus cannot stall, so every answer comes without wait states
`timescale 1ns/1ps

module mcs_mem_model (
	// clock
	input  wire logic        pclk,
	// memory bus
	input  wire logic [15:0] mem_addr,
	output logic      [7:0]  mem_rdata,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_data_oe,
	input  wire logic        mem_rd_n,
	input  wire logic        mem_wr_n,
	input  wire logic        program_fetch_strobe_n,
	input  wire logic        mem_ale,
	input  wire logic        mem_reset_n
);
	logic [7:0]  prog [256];
	logic [7:0]  dmem [65536];
	logic [7:0]  last;
	logic [15:0] latched;

	initial begin
		foreach (prog[i]) prog[i] = 8'h00;
		last = 8'h00;
		latched = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// address latch strobe
	always @(posedge pclk) begin
		if (mem_ale) begin
			latched <= mem_addr;
		end
		if (!mem_wr_n && mem_data_oe) begin
			dmem[latched] <= mem_wdata;
		end
		last <= mem_reset_n ? mem_rdata : 8'h00;
	end

	// read fetch strobes
	// released bus shows the inverse of its value one clock earlier, so it toggles and the last byte returns every second clock
	always @* begin
		if (!program_fetch_strobe_n) begin
			mem_rdata = prog[latched[7:0]];
		end else if (!mem_rd_n) begin
			mem_rdata = dmem[latched];
		end else begin
			mem_rdata = ~last;
		end
	end
endmodule

// ===== sim/mcu_machine_cycle_sequencer_test.sv
// self-checking bench of the machine cycle sequencer with the memory model on its far side
// assumes one apb wait state and that fetching starts at address zero once reset is released
`timescale 1ns/1ps

module mcu_machine_cycle_sequencer_test;
	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] mem_addr;
	logic [7:0]  mem_rdata;
	logic [7:0]  mem_wdata;
	logic        mem_data_oe;
	logic        mem_rd_n;
	logic        mem_wr_n;
	logic        program_fetch_strobe_n;
	logic        mem_ale;
	logic        mem_reset_n;
	int          err_count = 0;
	int          total_checks = 0;
	int          n = 0;
	int          wr_cnt = 0;
	int          rd_cnt = 0;
	int          fetch_time [$] = '{1, 7, 13, 19, 37, 43, 61, 67};
	logic [15:0] fetch_addr [$] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0003, 16'h0004, 16'h0004, 16'h0005};
	logic [7:0]  prog_img [7] = '{8'h74, 8'h5a, 8'hf0, 8'he2, 8'hd5, 8'h81, 8'hfd};
	int          rows [5] = '{0, 5, 11, 18, 22};
	logic [31:0] seed = 32'h0000_005f;
	logic [7:0]  exp_sfr [mcs_pkg::SFR_COUNT];
	logic [31:0] rd;
	logic [31:0] v;
	logic [7:0]  a;
	logic        er;

	mcs_sequencer i_mcs_sequencer (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_data_oe(mem_data_oe), .mem_rd_n(mem_rd_n),
		.mem_wr_n(mem_wr_n), .program_fetch_strobe_n(program_fetch_strobe_n), .mem_ale(mem_ale),
		.mem_reset_n(mem_reset_n));
	mcs_mem_model i_mcs_mem_model (.pclk(pclk), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
		.mem_data_oe(mem_data_oe), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
		.program_fetch_strobe_n(program_fetch_strobe_n), .mem_ale(mem_ale), .mem_reset_n(mem_reset_n));

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [11:0] sfr_paddr(input int i);
		return {2'b00, mcs_pkg::SFR_ADDR[i], 2'b00};
	endfunction

	// one apb transfer, entered and left right after a rising edge
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			err_count++;
			end_of_test();
		end
		r = prdata;
		e = pslverr;
	endtask

	task automatic idle(input int cycles);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (cycles) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		end_of_test();
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n <= 0;
		end else begin
			n <= n + 1;
		end
	end

	// watch the memory bus where its outputs have settled
	always @(negedge pclk) begin
		if (presetn && n > 0) begin
			if (!program_fetch_strobe_n) begin
				check("fetch phase", 32'(n % 12 == 1 || n % 12 == 7), 32'h1);
				if (fetch_time.size() > 0) begin
					check("fetch time", n, fetch_time.pop_front());
					check("fetch addr", {16'h0, mem_addr}, {16'h0, fetch_addr.pop_front()});
				end
			end
			if (mem_ale) begin
				check("latch phase", 32'(n % 12 == 0 || n % 12 == 6), 32'h1);
			end
			if (!mem_wr_n) wr_cnt++;
			if (!mem_rd_n) rd_cnt++;
		end
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		#1;
		foreach (prog_img[i]) i_mcs_mem_model.prog[i] = prog_img[i];
		i_mcs_mem_model.dmem[16'hff00] = 8'h3c;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// stack pointer is read before the loop starts decrementing it
		for (int i = 0; i < mcs_pkg::SFR_COUNT; i++) begin
			apb(1'b0, sfr_paddr(i), 32'h0, rd, er);
			check("sfr reset", rd, {24'h0, mcs_pkg::SFR_RESET[i]});
		end
		idle(330);
		apb(1'b0, sfr_paddr(1), 32'h0, rd, er);
		check("loop counter", rd, 32'h0);
		apb(1'b0, 12'h008, 32'h0, rd, er);
		check("moved byte", rd, 32'h3c);
		check("written byte", {24'h0, i_mcs_mem_model.dmem[16'h0000]}, 32'h5a);
		check("write strobe clocks", wr_cnt, 6);
		check("read strobe clocks", rd_cnt, 8);
		for (int i = 0; i < mcs_pkg::SFR_COUNT; i++) begin
			v = rnd();
			apb(1'b1, sfr_paddr(i), v, rd, er);
			exp_sfr[i] = mcs_pkg::SFR_READ_ONLY[i] ? mcs_pkg::SFR_RESET[i] : v[7:0];
		end
		for (int i = 0; i < mcs_pkg::SFR_COUNT; i++) begin
			apb(1'b0, sfr_paddr(i), 32'h0, rd, er);
			check("sfr value", rd, {24'h0, exp_sfr[i]});
		end
		apb(1'b1, 12'h210, 32'h0000_00a5, rd, er);
		apb(1'b0, 12'h210, 32'h0, rd, er);
		check("empty slot read", rd, 32'h0);
		check("empty slot error", {31'h0, er}, 32'h0);
		apb(1'b1, 12'h210, 32'h0, rd, er);
		apb(1'b0, sfr_paddr(3), 32'h0, rd, er);
		check("neighbour kept", rd, {24'h0, exp_sfr[3]});
		apb(1'b1, 12'hffc, rnd(), rd, er);
		check("unmapped error", {31'h0, er}, 32'h1);
		for (int r = 0; r < 5; r++) begin
			v = rnd();
			a = {mcs_pkg::SFR_ADDR[rows[r]][7:3], v[2:0]};
			apb(1'b1, 12'h010, {23'h0, v[8], a}, rd, er);
			exp_sfr[rows[r]][v[2:0]] = v[8];
			apb(1'b0, sfr_paddr(rows[r]), 32'h0, rd, er);
			check("bit write", rd, {24'h0, exp_sfr[rows[r]]});
			apb(1'b0, 12'h010, 32'h0, rd, er);
			check("bit read", rd, {23'h0, v[8], a});
		end
		apb(1'b1, 12'h000, 32'h3, rd, er);
		idle(2);
		check("memory reset on", {31'h0, mem_reset_n}, 32'h0);
		apb(1'b1, 12'h000, 32'h1, rd, er);
		idle(2);
		check("memory reset off", {31'h0, mem_reset_n}, 32'h1);
		idle(24);
		end_of_test();
	end
endmodule
